// ---- common/rgbpt_defines.vh ----
// Timing constants for the RGB panel timing and reset block
`ifndef RGBPT_DEFINES_VH
`define RGBPT_DEFINES_VH
// ====================================================
// Clock
`define RGBPT_CLK_MHZ 250
// ====================================================
// Line and field timing
`define RGBPT_HBP_24 11'h044
`define RGBPT_HACT_24 11'h140
`define RGBPT_HFP_24 11'h014
`define RGBPT_HMAX_24 11'h1c2
`define RGBPT_HBP_8 11'h0cc
`define RGBPT_HACT_8 11'h3c0
`define RGBPT_HFP_8 11'h03c
`define RGBPT_HMAX_8 11'h546
`define RGBPT_APL_24 10'h140
`define RGBPT_APL_8 10'h3c0
`define RGBPT_VBP 9'h012
`define RGBPT_VFP 9'h004
`define RGBPT_VACT_NTSC 9'h0f0
`define RGBPT_VACT_PAL0 9'h118
`define RGBPT_VACT_PAL1 9'h120
// ====================================================
// Reset timing, in microseconds and milliseconds
`define RGBPT_REJECT_US 5
`define RGBPT_FULL_US 9
`define RGBPT_LOAD_MS 5
`define RGBPT_BLANK_MS 120
// Cycle counts are the times in microseconds multiplied by the clock in MHz
`define RGBPT_REJECT_CYC (`RGBPT_REJECT_US * `RGBPT_CLK_MHZ)
`define RGBPT_FULL_CYC (`RGBPT_FULL_US * `RGBPT_CLK_MHZ)
`define RGBPT_LOAD_CYC (`RGBPT_LOAD_MS * 1000 * `RGBPT_CLK_MHZ)
`define RGBPT_BLANK_CYC (`RGBPT_BLANK_MS * 1000 * `RGBPT_CLK_MHZ)
// ====================================================
// Settings reset values
`define RGBPT_COMMON_VOLTAGE_SETTING_DEF 8'h40
`define RGBPT_ID_DEF 8'h5a
`endif

// ---- core/rgbpt_buf2.v ----
// Two-entry valid/ready buffer for received pixel words
`timescale 1ns/1ps
module rgbpt_buf2 #(
    parameter W = 26
) (
    input wire clk,
    input wire sys_rst,
    input wire [W-1:0] in_data,
    input wire in_valid,
    output wire in_ready,
    output wire [W-1:0] out_data,
    output wire out_valid,
    input wire out_ready
);
    reg [W-1:0] mem_r [0:1];
    reg wp_r;
    reg rp_r;
    reg [1:0] cnt_r;
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    assign in_ready = (cnt_r != 2'h2);
    assign out_valid = (cnt_r != 2'h0);
    assign out_data = mem_r[rp_r];
    always @(posedge clk) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end
    always @(posedge clk) begin
        if (sys_rst) begin
            wp_r <= 1'b0;
            rp_r <= 1'b0;
            cnt_r <= 2'h0;
        end else begin
            if (push) begin
                wp_r <= ~wp_r;
            end
            if (pop) begin
                rp_r <= ~rp_r;
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + 2'h1;
            end else if (pop && !push) begin
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end
endmodule // rgbpt_buf2

// ---- core/rgbpt_top.v ----
// Panel driver RGB receive timing and hardware reset handling
// Functional notes
// - Reject under 5us, reset above 9us
// - Spikes filtered during held reset too
// - Reload settings from storage after release
// - Awake reset runs blanking, at most 120ms
// - Sleeping reset keeps display blank throughout
// - Defaults loaded only at sys_rst; stored values loaded after reset period
`timescale 1ns/1ps
`include "rgbpt_defines.vh"
module rgbpt_top #(
    parameter REJECT_CYC = `RGBPT_REJECT_CYC,
    parameter FULL_CYC = `RGBPT_FULL_CYC,
    parameter LOAD_CYC = `RGBPT_LOAD_CYC,
    parameter BLANK_CYC = `RGBPT_BLANK_CYC,
    parameter FIELD_BP = `RGBPT_VBP
) (
    input wire clk,
    input wire sys_rst,
    input wire hw_reset_n,
    input wire pixel_clock,
    input wire hsync_n,
    input wire vsync_n,
    input wire [23:0] rgb_data,
    input wire mode_8bit,
    input wire pal_mode,
    input wire pal_line_count_select,
    input wire sleep_in,
    input wire [7:0] nvm_common_voltage_setting,
    input wire [7:0] nvm_id,
    output wire [23:0] pix_data,
    output wire pix_first,
    output wire pix_line_end,
    output wire pix_valid,
    input wire pix_ready,
    output reg [9:0] active_pixels_per_line,
    output reg [8:0] active_lines_per_field,
    output reg [7:0] common_voltage_setting,
    output reg [7:0] id_byte,
    output reg panel_in_reset,
    output reg display_blank,
    output reg cmd_ready,
    output reg wake_ready,
    output reg overflow
);
    // ====================================================
    // Synchronisers
    reg [1:0] rst_s1_r;
    reg [1:0] rst_s2_r;
    reg [1:0] pclk_s1_r;
    reg [1:0] pclk_s2_r;
    reg pclk_d_r;
    wire rst_lvl = rst_s2_r[0];
    wire hs_lvl = rst_s2_r[1];
    wire vs_lvl = pclk_s2_r[1];
    wire pclk_lvl = pclk_s2_r[0];
    wire pclk_rise = pclk_lvl && !pclk_d_r;
    // Data takes the same two stages as the clock, so both stay aligned
    reg [23:0] rgb_s1_r;
    reg [23:0] rgb_s2_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            rst_s1_r <= 2'h3;
            rst_s2_r <= 2'h3;
            pclk_s1_r <= 2'h3;
            pclk_s2_r <= 2'h3;
            pclk_d_r <= 1'b1;
            rgb_s1_r <= 24'h000000;
            rgb_s2_r <= 24'h000000;
        end else begin
            rst_s1_r <= {hsync_n, hw_reset_n};
            rst_s2_r <= rst_s1_r;
            pclk_s1_r <= {vsync_n, pixel_clock};
            pclk_s2_r <= pclk_s1_r;
            pclk_d_r <= pclk_lvl;
            rgb_s1_r <= rgb_data;
            rgb_s2_r <= rgb_s1_r;
        end
    end
    // ====================================================
    // Reset pulse filter and sequencer
    localparam ST_RUN = 3'h0;
    localparam ST_LOW = 3'h1;
    localparam ST_HELD = 3'h2;
    localparam ST_LOAD = 3'h3;
    localparam ST_BLANK = 3'h4;
    reg [2:0] st_r;
    reg [31:0] low_cnt_r;
    reg [31:0] hi_cnt_r;
    reg [31:0] tim_r;
    reg awake_r;
    always @(posedge clk) begin
        if (sys_rst) begin
            st_r <= ST_RUN;
            low_cnt_r <= 32'h0;
            hi_cnt_r <= 32'h0;
            // Power-up waits the same as a pin reset
            tim_r <= BLANK_CYC;
            awake_r <= 1'b0;
            panel_in_reset <= 1'b0;
            display_blank <= 1'b1;
            cmd_ready <= 1'b0;
            wake_ready <= 1'b0;
            common_voltage_setting <= `RGBPT_COMMON_VOLTAGE_SETTING_DEF;
            id_byte <= `RGBPT_ID_DEF;
        end else begin
            case (st_r)
                ST_RUN: begin
                    low_cnt_r <= 32'h0;
                    if (!rst_lvl) begin
                        st_r <= ST_LOW;
                    end
                    if (tim_r != 32'h0) begin
                        tim_r <= tim_r - 32'h1;
                    end
                    if (tim_r <= BLANK_CYC - LOAD_CYC) begin
                        cmd_ready <= 1'b1;
                    end
                    if (tim_r == 32'h0) begin
                        wake_ready <= 1'b1;
                    end
                    // Picture shown only once the wake wait is over
                    if (wake_ready) begin
                        display_blank <= sleep_in;
                    end
                end
                ST_LOW: begin
                    if (rst_lvl) begin
                        st_r <= ST_RUN;
                    end else if (low_cnt_r >= REJECT_CYC - 1) begin
                        // Between the limits, a reset starts anyway
                        st_r <= ST_HELD;
                        awake_r <= !sleep_in;
                        panel_in_reset <= 1'b1;
                        cmd_ready <= 1'b0;
                        wake_ready <= 1'b0;
                        hi_cnt_r <= 32'h0;
                        tim_r <= 32'h0;
                    end else begin
                        low_cnt_r <= low_cnt_r + 32'h1;
                    end
                end
                ST_HELD: begin
                    display_blank <= display_blank | !awake_r;
                    if (awake_r && tim_r >= BLANK_CYC - 1) begin
                        display_blank <= 1'b1;
                    end
                    if (tim_r < BLANK_CYC) begin
                        tim_r <= tim_r + 32'h1;
                    end
                    if (rst_lvl) begin
                        hi_cnt_r <= hi_cnt_r + 32'h1;
                        if (hi_cnt_r >= REJECT_CYC - 1) begin
                            st_r <= ST_LOAD;
                            tim_r <= 32'h0;
                        end
                    end else begin
                        hi_cnt_r <= 32'h0;
                    end
                end
                ST_LOAD: begin
                    display_blank <= 1'b1;
                    common_voltage_setting <= nvm_common_voltage_setting;
                    id_byte <= nvm_id;
                    tim_r <= tim_r + 32'h1;
                    if (tim_r >= LOAD_CYC - 1) begin
                        st_r <= ST_BLANK;
                    end
                end
                ST_BLANK: begin
                    panel_in_reset <= 1'b0;
                    display_blank <= 1'b1;
                    tim_r <= BLANK_CYC - LOAD_CYC;
                    st_r <= ST_RUN;
                end
                default: begin
                    st_r <= ST_RUN;
                end
            endcase
        end
    end
    // ====================================================
    // Video timing capture
    reg [10:0] hcnt_r;
    reg [8:0] vcnt_r;
    reg hs_d_r;
    reg vs_d_r;
    reg [10:0] hbp_r;
    reg [10:0] hact_r;
    reg [23:0] word_r;
    reg [1:0] sub_r;
    reg first_r;
    reg in_vld_r;
    reg [25:0] in_word_r;
    wire in_rdy;
    wire [25:0] out_word;
    always @(posedge clk) begin
        if (sys_rst || panel_in_reset) begin
            hcnt_r <= 11'h0;
            vcnt_r <= 9'h0;
            hs_d_r <= 1'b1;
            vs_d_r <= 1'b1;
            sub_r <= 2'h0;
            word_r <= 24'h000000;
            first_r <= 1'b0;
            in_vld_r <= 1'b0;
            in_word_r <= 26'h0;
            overflow <= 1'b0;
            hbp_r <= `RGBPT_HBP_24;
            hact_r <= `RGBPT_HACT_24;
            active_pixels_per_line <= `RGBPT_APL_24;
            active_lines_per_field <= `RGBPT_VACT_NTSC;
        end else begin
            if (in_vld_r && in_rdy) begin
                in_vld_r <= 1'b0;
            end
            hbp_r <= mode_8bit ? `RGBPT_HBP_8 : `RGBPT_HBP_24;
            hact_r <= mode_8bit ? `RGBPT_HACT_8 : `RGBPT_HACT_24;
            active_pixels_per_line <= mode_8bit ? `RGBPT_APL_8 : `RGBPT_APL_24;
            active_lines_per_field <= !pal_mode ? `RGBPT_VACT_NTSC :
                (pal_line_count_select ? `RGBPT_VACT_PAL1 : `RGBPT_VACT_PAL0);
            // work only on pixel clock edges
            if (pclk_rise) begin
                hs_d_r <= hs_lvl;
                vs_d_r <= vs_lvl;
                // Sync sample is position zero of the line
                if (!hs_lvl && hs_d_r) begin
                    hcnt_r <= 11'h1;
                    sub_r <= 2'h0;
                    if (vcnt_r != 9'h1ff) begin
                        vcnt_r <= vcnt_r + 9'h1;
                    end
                end else if (hcnt_r != 11'h7ff) begin
                    hcnt_r <= hcnt_r + 11'h1;
                end
                // Field start wins over the line count
                if (!vs_lvl && vs_d_r) begin
                    vcnt_r <= 9'h0;
                end
                if (vcnt_r >= FIELD_BP && vcnt_r < FIELD_BP + active_lines_per_field
                    && hcnt_r >= hbp_r && hcnt_r < hbp_r + hact_r) begin
                    if (mode_8bit) begin
                        word_r <= {word_r[15:0], rgb_s2_r[7:0]};
                        sub_r <= (sub_r == 2'h2) ? 2'h0 : sub_r + 2'h1;
                    end
                    if (!mode_8bit || sub_r == 2'h2) begin
                        // Stall beyond three words drops pixels; flagged, not hidden
                        if (in_vld_r && !in_rdy) begin
                            overflow <= 1'b1;
                        end
                        in_vld_r <= 1'b1;
                        in_word_r <= {hcnt_r == hbp_r + hact_r - 11'h1,
                            vcnt_r == FIELD_BP && hcnt_r == hbp_r + (mode_8bit ? 11'h2 : 11'h0),
                            mode_8bit ? {word_r[15:0], rgb_s2_r[7:0]} : rgb_s2_r};
                    end
                end
            end
        end
    end
    // ====================================================
    // Output buffer
    rgbpt_buf2 #(
        .W(26)
    ) u_buf (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(in_word_r),
        .in_valid(in_vld_r),
        .in_ready(in_rdy),
        .out_data(out_word),
        .out_valid(pix_valid),
        .out_ready(pix_ready)
    );
    assign pix_data = out_word[23:0];
    assign pix_first = out_word[24];
    assign pix_line_end = out_word[25];
endmodule // rgbpt_top

// ---- verif/rgbpt_assertions.sv ----
// Port checks for panel reset and pixel buffer
`timescale 1ns/1ps
module rgbpt_assertions #(
    parameter REJECT_CYC = 20,
    parameter FULL_CYC = 36,
    parameter LOAD_CYC = 200,
    parameter BLANK_CYC = 800
) (
    input wire clk,
    input wire sys_rst,
    input wire hw_reset_n,
    input wire [7:0] nvm_common_voltage_setting,
    input wire [7:0] nvm_id,
    input wire [23:0] pix_data,
    input wire pix_valid,
    input wire pix_ready,
    input wire [7:0] common_voltage_setting,
    input wire [7:0] id_byte,
    input wire panel_in_reset,
    input wire display_blank,
    input wire cmd_ready,
    input wire wake_ready
);
// ====================================
// Raw pin run lengths, saturating
reg [15:0] low_r;
reg [15:0] high_r;
// Time since the pin last let go of an accepted reset
reg [15:0] since_r;
// Cycles in reset with the picture still shown
reg [15:0] unblank_r;
always @(posedge clk) begin
    since_r <= (sys_rst || (panel_in_reset && !hw_reset_n)) ? 16'h0000 : since_r + {15'h0000, since_r != 16'hffff};
    unblank_r <= (sys_rst || !panel_in_reset || display_blank) ? 16'h0000 :
        unblank_r + {15'h0000, unblank_r != 16'hffff};
    low_r <= (sys_rst || hw_reset_n) ? 16'h0000 : low_r + {15'h0000, low_r != 16'hffff};
    high_r <= (sys_rst || !hw_reset_n) ? 16'h0000 : high_r + {15'h0000, high_r != 16'hffff};
end
default clocking @(posedge clk); endclocking
default disable iff (sys_rst);
// ====================================
// Sync delay allowed for, so threshold halved
a_spike_reject: assert property ($rose(panel_in_reset) |-> $past(low_r, 3) >= REJECT_CYC / 2)
    else $error("reset entered on short pulse");
a_full_accept: assert property (low_r >= FULL_CYC + 8 |-> panel_in_reset)
    else $error("long pulse not accepted");
a_glitch_hold: assert property ($fell(panel_in_reset) |-> high_r >= LOAD_CYC)
    else $error("reset left too early");
a_reload_nvm: assert property ($fell(panel_in_reset) |-> common_voltage_setting == nvm_common_voltage_setting && id_byte == nvm_id)
    else $error("settings not reloaded");
a_blank_stay: assert property (panel_in_reset && display_blank |=> display_blank || !panel_in_reset)
    else $error("display shown again during reset");
a_blank_bound: assert property (unblank_r <= BLANK_CYC)
    else $error("blanking sequence too long");
a_cmd_wait: assert property (cmd_ready |-> !panel_in_reset && since_r >= LOAD_CYC)
    else $error("commands allowed too early");
a_wake_wait: assert property (wake_ready |-> cmd_ready && since_r >= BLANK_CYC)
    else $error("wake allowed too early");
a_buf_hold: assert property (pix_valid && !pix_ready |=> pix_valid && $stable(pix_data))
    else $error("stalled word changed");
endmodule // rgbpt_assertions
bind rgbpt_top rgbpt_assertions #(.REJECT_CYC(REJECT_CYC), .FULL_CYC(FULL_CYC), .LOAD_CYC(LOAD_CYC),
    .BLANK_CYC(BLANK_CYC)) chk_u (.clk(clk), .sys_rst(sys_rst), .hw_reset_n(hw_reset_n),
    .nvm_common_voltage_setting(nvm_common_voltage_setting), .nvm_id(nvm_id), .pix_data(pix_data), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .common_voltage_setting(common_voltage_setting), .id_byte(id_byte), .panel_in_reset(panel_in_reset),
    .display_blank(display_blank), .cmd_ready(cmd_ready), .wake_ready(wake_ready));

// ---- verif/rgbpt_host_model.sv ----
// Host controller model driving the RGB stream
`timescale 1ns/1ps
module rgbpt_host_model (
    output reg pixel_clock,
    output reg hsync_n,
    output reg vsync_n,
    output reg [23:0] rgb_data
);
// ====================================
// Clock
// free running, panel stalls without it
initial begin
    pixel_clock = 1'b0;
    hsync_n = 1'b1;
    vsync_n = 1'b1;
    rgb_data = 24'h000000;
    forever #40 pixel_clock = ~pixel_clock;
end
function automatic [23:0] pix_word(input integer i);
    pix_word = {i[7:0], ~i[7:0], 8'h5a ^ i[15:8]};
endfunction
// ====================================
// One line, field start on first
// porches and active span
task automatic send_line(input m8, input first);
    integer c;
    integer bp;
    integer act;
    begin
        bp = m8 ? 204 : 68;
        act = m8 ? 960 : 320;
        for (c = 0; c < bp + act + (m8 ? 60 : 20); c++) begin
            @(negedge pixel_clock);
            hsync_n <= (c != 0);
            vsync_n <= !(first && c == 0);
            // Porches carry changing junk, not the last pixel
            if (c >= bp && c < bp + act) begin
                rgb_data <= m8 ? pix_word((c - bp) / 3) >> (8 * (2 - (c - bp) % 3)) : pix_word(c - bp);
            end else begin
                rgb_data <= ~rgb_data;
            end
        end
    end
endtask
endmodule // rgbpt_host_model

// ---- verif/rgbpt_top_tb.sv ----
// Self-checking bench for the panel receive and reset block
`timescale 1ns/1ps
`include "rgbpt_defines.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module rgbpt_top_tb;
reg clk, sys_rst, hw_reset_n, mode_8bit, pal_mode, pal_line_count_select, sleep_in, pix_ready;
reg [7:0] nvm_common_voltage_setting, nvm_id;
wire pixel_clock, hsync_n, vsync_n, pix_first, pix_line_end, pix_valid;
wire panel_in_reset, display_blank, cmd_ready, wake_ready, overflow;
wire [23:0] rgb_data, pix_data;
wire [9:0] active_pixels_per_line;
wire [8:0] active_lines_per_field;
wire [7:0] common_voltage_setting, id_byte;
integer bad_count = 0, n_checks = 0, cyc = 0;
rgbpt_host_model host (.pixel_clock(pixel_clock), .hsync_n(hsync_n), .vsync_n(vsync_n), .rgb_data(rgb_data));
rgbpt_top #(.REJECT_CYC(20), .FULL_CYC(36), .LOAD_CYC(200), .BLANK_CYC(800), .FIELD_BP(0)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .hw_reset_n(hw_reset_n), .pixel_clock(pixel_clock), .hsync_n(hsync_n),
    .vsync_n(vsync_n), .rgb_data(rgb_data), .mode_8bit(mode_8bit), .pal_mode(pal_mode),
    .pal_line_count_select(pal_line_count_select), .sleep_in(sleep_in), .nvm_common_voltage_setting(nvm_common_voltage_setting), .nvm_id(nvm_id),
    .pix_data(pix_data), .pix_first(pix_first), .pix_line_end(pix_line_end), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .active_pixels_per_line(active_pixels_per_line),
    .active_lines_per_field(active_lines_per_field), .common_voltage_setting(common_voltage_setting),
    .id_byte(id_byte), .panel_in_reset(panel_in_reset), .display_blank(display_blank),
    .cmd_ready(cmd_ready), .wake_ready(wake_ready), .overflow(overflow));
initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
end
task give_verdict;
    begin
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end
endtask
// ====================================
// Hang guard, runs need about 35k cycles
always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
        bad_count++;
        give_verdict;
    end
end
task t_modes;
    integer i;
    begin
        for (i = 0; i < 3; i++) begin
            pal_mode = (i > 0);
            pal_line_count_select = (i == 2);
            repeat (3) @(negedge clk);
            `CHK(active_lines_per_field, (i == 0) ? 9'h0f0 : (i == 1) ? 9'h118 : 9'h120)
        end
        `CHK(active_pixels_per_line, 10'h140)
        $display("modes done");
    end
endtask
task t_spike;
    integer i;
    begin
        hw_reset_n = 1'b0;
        repeat (10) @(negedge clk);
        hw_reset_n = 1'b1;
        for (i = 0; i < 30; i++) begin
            @(negedge clk);
            `CHK(panel_in_reset, 1'b0)
        end
        $display("spike done");
    end
endtask
task t_reset(input sl);
    integer c;
    begin
        sleep_in = sl;
        nvm_common_voltage_setting = sl ? 8'h21 : 8'h6e;
        nvm_id = sl ? 8'hc3 : 8'h17;
        hw_reset_n = 1'b0;
        repeat (30) @(negedge clk);
        // Short high glitch inside a held reset
        hw_reset_n = 1'b1;
        repeat (4) @(negedge clk);
        hw_reset_n = 1'b0;
        repeat (60) @(negedge clk);
        `CHK(panel_in_reset, 1'b1)
        `CHK(display_blank, sl)
        hw_reset_n = 1'b1;
        for (c = 0; c < 2000 && !wake_ready; c++) begin
            @(negedge clk);
            if (c == 100) `CHK(panel_in_reset, 1'b1)
            if (c == 100) `CHK(display_blank, 1'b1)
            if (c == 150) `CHK(cmd_ready, 1'b0)
            if (c == 700) `CHK(wake_ready, 1'b0)
        end
        `CHK(cmd_ready, 1'b1)
        `CHK(wake_ready, 1'b1)
        `CHK(common_voltage_setting, nvm_common_voltage_setting)
        `CHK(id_byte, nvm_id)
        @(negedge clk);
        `CHK(display_blank, sl)
        $display("reset sleep=%0d done", sl);
    end
endtask
task t_line(input m8);
    integer n, k;
    begin
        mode_8bit = m8;
        n = 0;
        fork
            host.send_line(m8, 1'b1);
            for (k = 0; k < 30000 && n < 320; k++) begin
                @(negedge clk);
                // Stall two of every four cycles
                pix_ready = k[1];
                if (pix_valid && pix_ready) begin
                    `CHK(pix_data, host.pix_word(n))
                    `CHK(pix_line_end, n == 319)
                    `CHK(pix_first, n == 0)
                    n++;
                end
            end
        join
        `CHK(n, 320)
        `CHK(active_pixels_per_line, m8 ? 10'h3c0 : 10'h140)
        `CHK(overflow, 1'b0)
        $display("line m8=%0d done", m8);
    end
endtask
initial begin
    sys_rst = 1'b1;
    hw_reset_n = 1'b1;
    mode_8bit = 1'b0;
    pal_mode = 1'b0;
    pal_line_count_select = 1'b0;
    sleep_in = 1'b0;
    pix_ready = 1'b1;
    nvm_common_voltage_setting = 8'h00;
    nvm_id = 8'h00;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    `CHK(common_voltage_setting, `RGBPT_COMMON_VOLTAGE_SETTING_DEF)
    `CHK(id_byte, `RGBPT_ID_DEF)
    t_modes;
    t_spike;
    // Wide line first: a later wide window never reopens on a stale count
    t_line(1'b1);
    t_line(1'b0);
    t_reset(1'b0);
    t_reset(1'b1);
    give_verdict;
end
endmodule // rgbpt_top_tb
